// ---- core/psp_pkg.sv ----
// Holds register map, field positions and serial constants.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data.
package psp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IRQ_N = 5;
	localparam int PORT_N = 3;
	localparam int SYNC_W = IRQ_N + 2;
	localparam logic [7:0] ADDR_POWER_CONTROL_REG = 8'h00;
	localparam logic [7:0] ADDR_IE = 8'h04;
	localparam logic [7:0] ADDR_SCTL = 8'h0C;
	localparam logic [7:0] ADDR_RXDATA = 8'h10;
	localparam logic [7:0] ADDR_IO_PORT_CONFIG = 8'hF8;
	localparam int POWER_CONTROL_REG_IDLE = 0;
	localparam int POWER_CONTROL_REG_SLEEP = 1;
	localparam int POWER_CONTROL_REG_PIN = 5;
	localparam int POWER_CONTROL_REG_WAKE = 6;
	localparam int IO_PORT_CONFIG_ALF = 0;
	localparam int IO_PORT_CONFIG_HZ = 1;
	localparam int IO_PORT_CONFIG_IZC = 4;
	localparam int IO_PORT_CONFIG_SERIAL_RX_ERROR_FLAG = 5;
	localparam int IE_GLOBAL = 7;
	localparam int SCTL_MODE = 0;
	localparam int SCTL_RXEN = 2;
	localparam int SCTL_T32 = 3;
	localparam int SCTL_DONE = 4;
	localparam logic [1:0] SMODE_1 = 2'h1;
	localparam logic [1:0] SMODE_2 = 2'h2;
	localparam logic [1:0] SMODE_3 = 2'h3;
	localparam int RX_CNT_W = 5;
	localparam logic [4:0] RX_SMP0 = 5'h06;
	localparam logic [4:0] RX_SMP2 = 5'h08;
	localparam logic [4:0] RX_LAST16 = 5'h0F;
	localparam logic [4:0] RX_LAST32 = 5'h1F;
	localparam logic [3:0] RX_BITS8 = 4'h8;
	localparam logic [3:0] RX_BITS9 = 4'h9;
endpackage : psp_pkg

// ---- core/psp_sync.sv ----
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module psp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			// Reset to the idle level of each pin, so no false edge follows
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end
		else
		begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end
	assign o_sync = sync_ff;
endmodule : psp_sync

// ---- core/psp_rx.sv ----
// Asynchronous serial receiver, oversampled by a tick enable.
// Assumes i_rxd is already synchronised and i_tick is a one-cycle pulse.
`timescale 1ns/1ps
module psp_rx (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic i_tick,
	input wire logic i_tick32,
	input wire logic i_nine_bits,
	input wire logic i_rxd,
	output logic o_done,
	output logic o_frame_err,
	output logic [8:0] o_data
);
	import psp_pkg::*;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} psp_rx_type;
	psp_rx_type state_ff;
	logic [RX_CNT_W-1:0] cnt_ff;
	logic [2:0] smp_ff;
	logic [8:0] shift_ff;
	logic [3:0] idx_ff;
	logic rxd_prev_ff;
	logic bit_val;
	logic last_tick;
	logic [3:0] nbits;
	assign bit_val = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2]) |
		(smp_ff[1] & smp_ff[2]);
	assign last_tick = i_tick & (cnt_ff == (i_tick32 ? RX_LAST32 : RX_LAST16));
	assign nbits = i_nine_bits ? RX_BITS9 : RX_BITS8;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			rxd_prev_ff <= 1'b1;
		else
			rxd_prev_ff <= i_rxd;
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !i_enable)
		begin
			state_ff <= RX_IDLE;
			cnt_ff <= '0;
			smp_ff <= '0;
			idx_ff <= '0;
			shift_ff <= '0;
		end
		else if (state_ff == RX_IDLE)
		begin
			cnt_ff <= '0;
			idx_ff <= '0;
			if (rxd_prev_ff && !i_rxd)
				state_ff <= RX_START;
		end
		else if (i_tick)
		begin
			cnt_ff <= last_tick ? '0 : cnt_ff + 1'b1;
			if (cnt_ff >= RX_SMP0 && cnt_ff <= RX_SMP2)
				smp_ff <= {smp_ff[1:0], i_rxd};
			if (last_tick)
			begin
				unique case (state_ff)
					RX_START: state_ff <= bit_val ? RX_IDLE : RX_DATA;
					RX_DATA:
					begin
						shift_ff <= {bit_val, shift_ff[8:1]};
						idx_ff <= idx_ff + 1'b1;
						if (idx_ff == nbits - 1'b1)
							state_ff <= RX_STOP;
					end
					RX_STOP: state_ff <= RX_IDLE;
					RX_IDLE: state_ff <= RX_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_done <= 1'b0;
			o_frame_err <= 1'b0;
			o_data <= '0;
		end
		else
		begin
			o_done <= 1'b0;
			o_frame_err <= 1'b0;
			if (i_enable && last_tick && state_ff == RX_STOP)
			begin
				o_done <= 1'b1;
				o_frame_err <= ~bit_val;
				o_data <= i_nine_bits ? shift_ff : {1'b0, shift_ff[8:1]};
			end
		end
	end
endmodule : psp_rx

// ---- core/psp_ctrl.sv ----
// Power-down sequencer, serial error detection and port impedance control.
// Assumes an Avalon-MM master on i_clk and pin inputs from outside.
`timescale 1ns/1ps
module psp_ctrl (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [psp_pkg::ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [psp_pkg::DATA_W-1:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [psp_pkg::DATA_W-1:0] o_readdata,
	output logic o_waitrequest,
	input wire logic [psp_pkg::IRQ_N-1:0] i_irq_pin,
	input wire logic i_timer1_input_pin,
	input wire logic i_rxd,
	input wire logic i_rx_tick,
	input wire logic i_instr_end,
	output logic o_sleep,
	output logic o_idle,
	output logic o_core_run,
	output logic o_resume_vector,
	output logic o_resume_next,
	output logic [psp_pkg::PORT_N-1:0] o_port_float,
	output logic [psp_pkg::PORT_N-1:0] o_port_pullup_100k,
	output logic o_serial_rx_error_flag,
	output logic o_rx_done_flag
);
	import psp_pkg::*;

	// ==========================================================
	// Pin synchronisers
	typedef enum logic {PS_RUN, PS_SLEEP} psp_pwr_type;
	logic [SYNC_W-1:0] sync_bus;
	logic t1_s;
	logic rxd_s;
	logic [IRQ_N-1:0] irq_s;
	logic t1_prev_ff;
	logic t1_rise;
	logic t1_fall;

	psp_sync #(
		.WIDTH(SYNC_W),
		.RST_VAL({{IRQ_N{1'b0}}, 2'h3})
	) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_irq_pin, i_rxd, i_timer1_input_pin}),
		.o_sync(sync_bus)
	);
	assign t1_s = sync_bus[0];
	assign rxd_s = sync_bus[1];
	assign irq_s = sync_bus[SYNC_W-1:2];

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			t1_prev_ff <= 1'b1;
		else
			t1_prev_ff <= t1_s;
	end
	assign t1_rise = t1_s & ~t1_prev_ff;
	assign t1_fall = ~t1_s & t1_prev_ff;

	// ==========================================================
	// Avalon-MM slave
	logic ack_ff;
	logic wr_en;
	logic wr_power_control_reg;
	logic wr_ie;
	logic wr_sctl;
	logic wr_io_port_config;
	logic [DATA_W-1:0] rd_val;
	logic [DATA_W-1:0] readdata_ff;
	logic [7:0] wd;

	assign o_waitrequest = (i_read | i_write) & ~ack_ff;
	assign wr_en = i_write & ack_ff & i_byteenable[0];
	assign wd = i_writedata[7:0];
	assign wr_power_control_reg = wr_en & (i_address == ADDR_POWER_CONTROL_REG);
	assign wr_ie = wr_en & (i_address == ADDR_IE);
	assign wr_sctl = wr_en & (i_address == ADDR_SCTL);
	assign wr_io_port_config = wr_en & (i_address == ADDR_IO_PORT_CONFIG);
	assign o_readdata = readdata_ff;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ack_ff <= 1'b0;
		else
			ack_ff <= (i_read | i_write) & ~ack_ff;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			readdata_ff <= '0;
		else if (i_read && !ack_ff)
			readdata_ff <= rd_val;
	end

	// ==========================================================
	// Register state
	logic idle_req_ff;
	logic sleep_req_ff;
	logic pin_sleep_en_ff;
	logic irq_wake_en_ff;
	logic [7:0] ie_ff;
	logic alf_ff;
	logic izc_ff;
	logic [PORT_N-1:0] hz_ff;
	logic serial_rx_error_flag_ff;
	logic rx_done_ff;
	logic [1:0] smode_ff;
	logic rx_en_ff;
	logic tick32_ff;
	logic [8:0] rx_data;

	always_comb
	begin
		rd_val = '0;
		case (i_address)
			ADDR_POWER_CONTROL_REG:
			begin
				rd_val[POWER_CONTROL_REG_IDLE] = idle_req_ff;
				rd_val[POWER_CONTROL_REG_SLEEP] = sleep_req_ff;
				rd_val[POWER_CONTROL_REG_PIN] = pin_sleep_en_ff;
				rd_val[POWER_CONTROL_REG_WAKE] = irq_wake_en_ff;
			end
			ADDR_IE: rd_val[7:0] = ie_ff;
			ADDR_SCTL:
			begin
				rd_val[SCTL_MODE+:2] = smode_ff;
				rd_val[SCTL_RXEN] = rx_en_ff;
				rd_val[SCTL_T32] = tick32_ff;
				rd_val[SCTL_DONE] = rx_done_ff;
			end
			ADDR_RXDATA: rd_val[8:0] = rx_data;
			ADDR_IO_PORT_CONFIG:
			begin
				rd_val[IO_PORT_CONFIG_ALF] = alf_ff;
				rd_val[IO_PORT_CONFIG_HZ+:PORT_N] = hz_ff;
				rd_val[IO_PORT_CONFIG_IZC] = izc_ff;
				rd_val[IO_PORT_CONFIG_SERIAL_RX_ERROR_FLAG] = serial_rx_error_flag_ff;
			end
			default: rd_val = '0;
		endcase
	end

	// ==========================================================
	// Power-down and idle sequencing
	psp_pwr_type pwr_state_ff;
	logic pin_pend_ff;
	logic any_irq;
	logic enabled_irq;
	logic combined;
	logic hw_only;
	logic enter_sleep;
	logic sleep_exit;
	logic idle_exit;
	logic wake_any;

	assign any_irq = |irq_s;
	assign enabled_irq = ie_ff[IE_GLOBAL] & (|(irq_s & ie_ff[IRQ_N-1:0]));
	assign combined = (pin_sleep_en_ff & sleep_req_ff) | idle_req_ff;
	assign hw_only = pin_sleep_en_ff & ~combined;
	assign enter_sleep = sleep_req_ff | (pin_pend_ff & i_instr_end);

	always_comb
	begin
		sleep_exit = 1'b0;
		if (pwr_state_ff == PS_SLEEP)
		begin
			if (combined)
				sleep_exit = t1_s & irq_wake_en_ff & any_irq;
			else if (pin_sleep_en_ff)
				sleep_exit = t1_rise;
			else
				sleep_exit = (irq_wake_en_ff & any_irq) | enabled_irq;
		end
	end
	assign idle_exit = (pwr_state_ff == PS_RUN) & idle_req_ff &
		(enabled_irq | (irq_wake_en_ff & any_irq));
	assign wake_any = sleep_exit | idle_exit;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			pwr_state_ff <= PS_RUN;
		else
		begin
			unique case (pwr_state_ff)
				PS_RUN:
					if (enter_sleep)
						pwr_state_ff <= PS_SLEEP;
				PS_SLEEP:
					if (sleep_exit)
						pwr_state_ff <= PS_RUN;
			endcase
		end
	end

	// Falling timer 1 edge waits for the running instruction to finish
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			pin_pend_ff <= 1'b0;
		else if (!pin_sleep_en_ff || pwr_state_ff == PS_SLEEP)
			pin_pend_ff <= 1'b0;
		else if (i_instr_end)
			pin_pend_ff <= 1'b0;
		else if (t1_fall)
			pin_pend_ff <= 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			idle_req_ff <= 1'b0;
			sleep_req_ff <= 1'b0;
			pin_sleep_en_ff <= 1'b0;
			irq_wake_en_ff <= 1'b0;
		end
		else
		begin
			if (wr_power_control_reg)
			begin
				idle_req_ff <= wd[POWER_CONTROL_REG_IDLE];
				sleep_req_ff <= wd[POWER_CONTROL_REG_SLEEP];
				pin_sleep_en_ff <= wd[POWER_CONTROL_REG_PIN];
				irq_wake_en_ff <= wd[POWER_CONTROL_REG_WAKE];
			end
			if (wake_any)
			begin
				idle_req_ff <= 1'b0;
				sleep_req_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ie_ff <= '0;
		else if (wr_ie)
			ie_ff <= wd;
	end

	// Hardware-only wake ignores interrupts and resumes in line
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_resume_vector <= 1'b0;
			o_resume_next <= 1'b0;
		end
		else
		begin
			o_resume_vector <= wake_any & enabled_irq & ~hw_only;
			o_resume_next <= wake_any & ~(enabled_irq & ~hw_only);
		end
	end

	assign o_sleep = (pwr_state_ff == PS_SLEEP);
	assign o_idle = idle_req_ff & ~o_sleep;
	assign o_core_run = ~(o_sleep | o_idle);

	// ==========================================================
	// Port impedance
	logic [PORT_N-1:0] nxt_port_float;
	logic [PORT_N-1:0] port_float_ff;
	logic [PORT_N-1:0] pullup_ff;

	assign nxt_port_float = {PORT_N{alf_ff & o_sleep}} | hz_ff;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			port_float_ff <= '0;
			pullup_ff <= '0;
		end
		else
		begin
			port_float_ff <= nxt_port_float;
			pullup_ff <= ~nxt_port_float & {PORT_N{izc_ff}};
		end
	end
	assign o_port_float = port_float_ff;
	assign o_port_pullup_100k = pullup_ff;

	// ==========================================================
	// Serial receive and error flags
	logic rx_active;
	logic rx_done_evt;
	logic rx_frame_err;

	// Frozen core keeps only the timer-clocked modes alive
	assign rx_active = rx_en_ff & (o_core_run | smode_ff == SMODE_1 |
		smode_ff == SMODE_3);

	// Ticks come from timer 1 counting its external input
	psp_rx u_rx (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_enable(rx_active),
		.i_tick(i_rx_tick),
		.i_tick32(tick32_ff),
		.i_nine_bits(smode_ff[1]),
		.i_rxd(rxd_s),
		.o_done(rx_done_evt),
		.o_frame_err(rx_frame_err),
		.o_data(rx_data)
	);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			smode_ff <= '0;
			rx_en_ff <= 1'b0;
			tick32_ff <= 1'b0;
		end
		else if (wr_sctl)
		begin
			smode_ff <= wd[SCTL_MODE+:2];
			rx_en_ff <= wd[SCTL_RXEN];
			tick32_ff <= wd[SCTL_T32];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			rx_done_ff <= 1'b0;
		else if (rx_done_evt)
			rx_done_ff <= 1'b1;
		else if (wr_sctl)
			rx_done_ff <= wd[SCTL_DONE];
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			alf_ff <= 1'b0;
			izc_ff <= 1'b0;
			hz_ff <= '0;
		end
		else if (wr_io_port_config)
		begin
			alf_ff <= wd[IO_PORT_CONFIG_ALF];
			izc_ff <= wd[IO_PORT_CONFIG_IZC];
			hz_ff <= wd[IO_PORT_CONFIG_HZ+:PORT_N];
		end
	end

	// Error events win over a software clear in the same cycle
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			serial_rx_error_flag_ff <= 1'b0;
		else if (rx_done_evt && (rx_frame_err || rx_done_ff))
			serial_rx_error_flag_ff <= 1'b1;
		else if (wr_io_port_config)
			serial_rx_error_flag_ff <= wd[IO_PORT_CONFIG_SERIAL_RX_ERROR_FLAG];
	end
	assign o_serial_rx_error_flag = serial_rx_error_flag_ff;
	assign o_rx_done_flag = rx_done_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_sw_entry: assert property (
		pwr_state_ff == PS_RUN && sleep_req_ff |=> o_sleep)
		else $error("sleep request did not enter power-down");
	a_sw_hold: assert property (
		o_sleep && !pin_sleep_en_ff && !idle_req_ff && !irq_wake_en_ff &&
		!enabled_irq |=> o_sleep)
		else $error("power-down left without cause");
	a_irq_wake: assert property (
		o_sleep && !pin_sleep_en_ff && !idle_req_ff && irq_wake_en_ff &&
		any_irq |=> !o_sleep && (o_resume_vector || o_resume_next))
		else $error("interrupt request did not wake");
	a_vec_resume: assert property (
		o_sleep && !pin_sleep_en_ff && !idle_req_ff && enabled_irq
		|=> o_resume_vector && !o_resume_next)
		else $error("enabled wake did not vector");
	a_next_resume: assert property (
		o_sleep && !pin_sleep_en_ff && !idle_req_ff && irq_wake_en_ff &&
		any_irq && !enabled_irq |=> o_resume_next)
		else $error("masked wake did not resume in line");
	a_pin_entry: assert property (
		$fell(t1_s) && pin_sleep_en_ff && !o_sleep && !i_instr_end
		##1 i_instr_end[*1] |=> o_sleep)
		else $error("pin fall did not enter power-down");
	a_comb_hold: assert property (
		o_sleep && combined && !(t1_s && irq_wake_en_ff && any_irq)
		|=> o_sleep)
		else $error("combined power-down left early");
	a_idle_pd: assert property (
		o_sleep && idle_req_ff && t1_s && irq_wake_en_ff && any_irq
		|=> !o_sleep && !idle_req_ff)
		else $error("power-down with idle not exited");
	a_hw_exit: assert property (
		o_sleep && hw_only && !t1_rise |=> o_sleep)
		else $error("hardware power-down left without pin rise");
	a_frame_err: assert property (
		rx_done_evt && rx_frame_err |=> serial_rx_error_flag_ff)
		else $error("framing error not flagged");
	a_rx_flag: assert property (
		rx_done_evt |=> rx_done_ff ##1 (rx_done_ff || $past(wr_sctl)))
		else $error("receive-complete flag lost");
	a_overrun: assert property (
		rx_done_evt && rx_done_ff |=> serial_rx_error_flag_ff && rx_done_ff)
		else $error("overrun not flagged");
	a_serial_rx_error_flag_sticky: assert property (
		serial_rx_error_flag_ff && !wr_io_port_config |=> serial_rx_error_flag_ff)
		else $error("error flag cleared by hardware");
	a_frozen_rx: assert property (
		!o_core_run && smode_ff == SMODE_2 |-> !rx_active)
		else $error("mode 2 active with frozen core");
	a_all_float: assert property (
		o_sleep && alf_ff |=> o_port_float == {PORT_N{1'b1}})
		else $error("ports driven in power-down with all float");
	a_pullup_sel: assert property (
		!o_sleep && !$changed(hz_ff) && !$changed(izc_ff)
		|=> o_port_float == $past(hz_ff) &&
		o_port_pullup_100k == (~$past(hz_ff) & {PORT_N{$past(izc_ff)}}))
		else $error("port impedance mismatch");

	c_irq_wake: cover property (o_sleep && irq_wake_en_ff ##1 !o_sleep);
	c_hw_cycle: cover property (o_sleep && hw_only ##1 o_resume_next);
	c_overrun: cover property (rx_done_evt && rx_done_ff);
	c_frame: cover property (rx_done_evt && rx_frame_err);
endmodule : psp_ctrl

// ---- test/psp_peer.sv ----
// Serial line peer and receive oversample tick source for the control bench.
// Assumes the bench calls send() from its main process, one frame at a time.
`timescale 1ns/1ps
module psp_peer (
	input wire logic i_clk,
	output logic o_tick,
	output logic o_rxd
);
	logic [1:0] div_ff = 2'h0;
	initial
	begin
		o_tick = 1'b0;
		o_rxd = 1'b1;
	end
	// ==========================================================
	// Oversample tick, one pulse every fourth clock
	always @(posedge i_clk)
	begin
		div_ff <= div_ff + 2'h1;
		o_tick <= (div_ff == 2'h3);
	end
	// ==========================================================
	// Frame: start low, eight bits LSB first, stop; 16 ticks a bit
	task automatic send(input logic [7:0] b, input logic stp, input bit glt);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++)
			for (int t = 0; t < 16; t++)
			begin
				do @(posedge i_clk); while (o_tick !== 1'b1);
				o_rxd <= (glt && i == 1 && t == 7) ? ~f[i] : f[i];
			end
		do @(posedge i_clk); while (o_tick !== 1'b1);
		o_rxd <= 1'b1;
	endtask : send
endmodule : psp_peer

// ---- test/psp_ctrl_tb.sv ----
// Self-checking bench for power-down, receive errors and port impedance.
// Assumes psp_peer drives the serial line and the receive tick.
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
		end \
	end
module psp_ctrl_tb;
	import psp_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [ADDR_W-1:0] i_address = '0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [DATA_W-1:0] i_writedata = '0;
	logic [3:0] i_byteenable = 4'hF;
	logic [IRQ_N-1:0] i_irq_pin = '0;
	logic i_timer1_input_pin = 1'b1;
	logic i_instr_end = 1'b0;
	logic rxd, tick;
	logic [DATA_W-1:0] o_readdata;
	logic o_waitrequest, o_sleep, o_idle, o_core_run;
	logic o_resume_vector, o_resume_next;
	logic [PORT_N-1:0] o_port_float, o_port_pullup_100k;
	logic o_serial_rx_error_flag, o_rx_done_flag;
	int error_cnt = 0;
	int total_checks = 0;
	int seed = 4;
	int vec_cnt = 0;
	int next_cnt = 0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] r;
	always #10 i_clk = ~i_clk;
	psp_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_irq_pin(i_irq_pin),
		.i_timer1_input_pin(i_timer1_input_pin), .i_rxd(rxd),
		.i_rx_tick(tick), .i_instr_end(i_instr_end), .o_sleep(o_sleep),
		.o_idle(o_idle), .o_core_run(o_core_run),
		.o_resume_vector(o_resume_vector), .o_resume_next(o_resume_next),
		.o_port_float(o_port_float), .o_port_pullup_100k(o_port_pullup_100k),
		.o_serial_rx_error_flag(o_serial_rx_error_flag),
		.o_rx_done_flag(o_rx_done_flag));
	psp_peer peer (.i_clk(i_clk), .o_tick(tick), .o_rxd(rxd));
	// ==========================================================
	// Result watcher: read data against the oldest note, wake pulses
	always @(posedge i_clk)
	begin
		if (i_read && o_waitrequest === 1'b0 && exp_q.size() > 0)
		begin
			`CHK(o_readdata & msk_q[0], exp_q[0])
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		if (o_resume_vector === 1'b1)
			vec_cnt++;
		if (o_resume_next === 1'b1)
			next_cnt++;
	end
	// ==========================================================
	// Bus and helper tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m);
		int n;
		n = 0;
		if (!wr)
		begin
			exp_q.push_back(d & m);
			msk_q.push_back(m);
		end
		@(posedge i_clk);
		i_address <= a;
		i_write <= wr;
		i_read <= !wr;
		i_writedata <= wr ? d : 32'h0;
		do
		begin
			@(posedge i_clk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			error_cnt++;
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		bus(1'b0, a, e, m);
	endtask : rd
	task automatic do_reset;
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		cyc(10);
		i_rst_n <= 1'b1;
		cyc(1);
	endtask : do_reset
	task automatic conclude;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	// ==========================================================
	// Watchdog
	initial
	begin
		cyc(60000);
		error_cnt++;
		conclude();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		logic [7:0] regs[6] = '{ADDR_POWER_CONTROL_REG, ADDR_IE, ADDR_SCTL, ADDR_RXDATA,
			ADDR_IO_PORT_CONFIG, 8'h40};
		cyc(10);
		i_rst_n <= 1'b1;
		foreach (regs[i])
			rd(regs[i], 32'h0, 32'hFFFFFFFF);
		`CHK(o_core_run, 1'b1)
		for (int k = 0; k < 32; k++)
		begin
			r = k;
			wr(ADDR_IO_PORT_CONFIG, r);
			rd(ADDR_IO_PORT_CONFIG, r, 32'hFF);
			cyc(2);
			`CHK(o_port_float, r[3:1])
			`CHK(o_port_pullup_100k & ~r[3:1], {3{r[4]}} & ~r[3:1])
		end
		// Software power-down, wake disabled
		wr(ADDR_IO_PORT_CONFIG, 32'h11);
		wr(ADDR_POWER_CONTROL_REG, 32'h02);
		cyc(3);
		`CHK(o_sleep, 1'b1)
		`CHK(o_core_run, 1'b0)
		`CHK(o_port_float, 3'h7)
		i_irq_pin <= 5'h1F;
		cyc(8);
		`CHK(o_sleep, 1'b1)
		i_irq_pin <= '0;
		do_reset();
		`CHK(o_sleep, 1'b0)
		`CHK(o_port_float, 3'h0)
		// Masked request from each source
		for (int s = 0; s < IRQ_N; s++)
		begin
			wr(ADDR_POWER_CONTROL_REG, 32'h42);
			cyc(3);
			i_irq_pin[s] <= 1'b1;
			cyc(6);
			`CHK(o_sleep, 1'b0)
			i_irq_pin <= '0;
			cyc(4);
		end
		`CHK(next_cnt, IRQ_N)
		`CHK(vec_cnt, 0)
		// Enabled request
		r = $unsigned($random(seed)) % IRQ_N;
		wr(ADDR_IE, 32'h80 | (32'h1 << r));
		wr(ADDR_POWER_CONTROL_REG, 32'h42);
		cyc(3);
		i_irq_pin[r] <= 1'b1;
		cyc(6);
		`CHK(o_sleep, 1'b0)
		`CHK(vec_cnt, 1)
		i_irq_pin <= '0;
		wr(ADDR_IE, 32'h0);
		// Pin-controlled power-down
		wr(ADDR_POWER_CONTROL_REG, 32'h20);
		i_timer1_input_pin <= 1'b0;
		cyc(5);
		`CHK(o_sleep, 1'b0)
		i_instr_end <= 1'b1;
		cyc(1);
		i_instr_end <= 1'b0;
		cyc(2);
		`CHK(o_sleep, 1'b1)
		i_irq_pin <= 5'h1F;
		cyc(8);
		`CHK(o_sleep, 1'b1)
		i_irq_pin <= '0;
		cyc(3);
		i_timer1_input_pin <= 1'b1;
		cyc(6);
		`CHK(o_sleep, 1'b0)
		`CHK(next_cnt, IRQ_N + 1)
		// Combined mode with idle, pin held low
		wr(ADDR_POWER_CONTROL_REG, 32'h0);
		i_timer1_input_pin <= 1'b0;
		cyc(4);
		wr(ADDR_POWER_CONTROL_REG, 32'h63);
		cyc(3);
		`CHK(o_sleep, 1'b1)
		`CHK(o_core_run, 1'b0)
		rd(ADDR_POWER_CONTROL_REG, 32'h63, 32'hFF);
		i_irq_pin <= 5'h04;
		cyc(8);
		`CHK(o_sleep, 1'b1)
		i_timer1_input_pin <= 1'b1;
		cyc(6);
		`CHK(o_sleep, 1'b0)
		i_irq_pin <= '0;
		wr(ADDR_POWER_CONTROL_REG, 32'h0);
		// Serial receive, overrun, framing, sticky error
		wr(ADDR_SCTL, 32'h05);
		r = $random(seed) & 32'hFF;
		peer.send(r[7:0], 1'b1, 1'b1);
		cyc(4);
		`CHK(o_rx_done_flag, 1'b1)
		`CHK(o_serial_rx_error_flag, 1'b0)
		rd(ADDR_RXDATA, r, 32'hFF);
		peer.send(8'hA5, 1'b1, 1'b0);
		cyc(4);
		`CHK(o_serial_rx_error_flag, 1'b1)
		wr(ADDR_SCTL, 32'h05);
		cyc(2);
		`CHK(o_rx_done_flag, 1'b0)
		`CHK(o_serial_rx_error_flag, 1'b1)
		wr(ADDR_IO_PORT_CONFIG, 32'h0);
		cyc(2);
		`CHK(o_serial_rx_error_flag, 1'b0)
		peer.send(8'h3C, 1'b0, 1'b0);
		cyc(4);
		rd(ADDR_IO_PORT_CONFIG, 32'h20, 32'h20);
		// Reception with the core frozen: mode 1 runs, mode 2 does not
		wr(ADDR_IO_PORT_CONFIG, 32'h0);
		wr(ADDR_SCTL, 32'h05);
		wr(ADDR_POWER_CONTROL_REG, 32'h02);
		peer.send(8'h5A, 1'b1, 1'b0);
		cyc(4);
		`CHK(o_rx_done_flag, 1'b1)
		do_reset();
		wr(ADDR_SCTL, 32'h06);
		wr(ADDR_POWER_CONTROL_REG, 32'h02);
		peer.send(8'h5A, 1'b1, 1'b0);
		cyc(80);
		`CHK(o_rx_done_flag, 1'b0)
		do_reset();
		conclude();
	end
endmodule : psp_ctrl_tb
